// *** shared/bpo_port_map.vh ***
// register map, field positions and reset values of the bidirectional port
// assumes a classic wishbone slave with 32-bit data and byte addresses
`ifndef BPO_PORT_MAP_VH
`define BPO_PORT_MAP_VH

// byte offsets of the port registers
`define BPO_ADDR_PINS       8'h00
`define BPO_ADDR_LATCH      8'h04
`define BPO_ADDR_DIR        8'h08
`define BPO_ADDR_ANALOG     8'h0C
`define BPO_ADDR_PERIPH     8'h10

// port width and address decode width
`define BPO_PORT_W          8
`define BPO_ADDR_W          8

// reset values
`define BPO_RST_LATCH       8'h00
`define BPO_RST_DIR         8'hFF
`define BPO_RST_ANALOG      8'h00
`define BPO_RST_PERIPH      8'h00

// bit positions in the peripheral enable register
`define BPO_PE_OSC          0
`define BPO_PE_LCD          1
`define BPO_PE_SER_CLK      2
`define BPO_PE_SER_DAT      3
`define BPO_PE_UART         4
`define BPO_PE_CC1          5
`define BPO_PE_CC2          6
`define BPO_PE_CC3          7

// bit positions of pins inside a byte
`define BPO_PIN0            0
`define BPO_PIN1            1
`define BPO_PIN2            2
`define BPO_PIN3            3
`define BPO_PIN4            4
`define BPO_PIN5            5
`define BPO_PIN6            6
`define BPO_PIN7            7

// zero word used for unused upper read bits
`define BPO_ZERO24          24'h000000
`define BPO_ONE             1'b1
`define BPO_ZERO            1'b0

`endif

// *** sim/bpo_pins_model.sv ***
// circuitry outside the eight port pins
// assumes active-low driver enables; undriven pins wander
module bpo_pins_model
(
	// clock for the wander pattern
	input  wire logic       clk_i,
	// port side
	input  wire logic [7:0] drv_i,
	input  wire logic [7:0] oe_n_i,
	// outside drivers
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	// resolved pins
	output logic      [7:0] pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tgl_ff = 8'h55; // floating pins never settle
	// toggles so a floating pin is never read as a clean level
	always @(posedge clk_i)
		tgl_ff <= ~tgl_ff;
	// port wins where it drives, else outside, else noise
	assign pins_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_val_i)
		| (oe_n_i & ~ext_en_i & tgl_ff);
endmodule // bpo_pins_model

// *** sim/bpo_port_assertions.sv ***
// assertion checker for the bidirectional port
// assumes writes land at the taking edge, pins follow one edge later
module bpo_port_chk
(
	// clock, reset, bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// peripherals
	input wire logic        secondary_osc_output_i,
	input wire logic [7:0]  lcd_segment_line_i,
	input wire logic        uart_sync_clock_i,
	input wire logic        capcomp2_output_a_i,
	input wire logic        capcomp2_output_b_i,
	// pins
	input wire logic [7:0]  third_port_pins_o,
	input wire logic [7:0]  third_port_pins_oe_n_o
);
	logic [7:0] pe_ff;  // peripheral enable shadow
	logic [7:0] dir_ff; // direction shadow
	logic [7:0] lat_ff; // latch shadow
	logic       wr;     // byte write on the bus
	assign wr = cyc_i && stb_i && we_i && sel_i[0];
	// shadows; a retaken write repeats its value, so harmless
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pe_ff <= 8'h00;
			dir_ff <= 8'hFF;
			lat_ff <= 8'h00;
		end
		else if (wr && adr_i == 8'h10)
			pe_ff <= dat_i[7:0];
		else if (wr && adr_i == 8'h08)
			dir_ff <= dat_i[7:0];
		else if (wr && (adr_i == 8'h04 || adr_i == 8'h00))
			lat_ff <= dat_i[7:0];
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		$rose(stb_i) && cyc_i;
	endsequence
	sequence s_ans;
		!ack_o ##1 ack_o ##1 !ack_o;
	endsequence
	property p_ack;
		s_req |=> s_ans;
	endproperty
	property p_upper;
		ack_o |-> dat_o[31:8] == 24'h000000;
	endproperty
	property p_rst;
		disable iff (1'b0) rst_i |=> third_port_pins_oe_n_o == 8'hFF && third_port_pins_o == 8'h00;
	endproperty
	property p_dflt;
		pe_ff == 8'h00 |=> third_port_pins_oe_n_o == $past(dir_ff)
			&& (third_port_pins_o & ~third_port_pins_oe_n_o) == ($past(lat_ff) & ~$past(dir_ff));
	endproperty
	property p_osc;
		pe_ff[0] |=> !third_port_pins_oe_n_o[0] && third_port_pins_oe_n_o[1]
			&& third_port_pins_o[0] == $past(secondary_osc_output_i);
	endproperty
	property p_lcd;
		pe_ff[1] |=> third_port_pins_oe_n_o[7:2] == 6'h00
			&& third_port_pins_o[7:2] == $past(lcd_segment_line_i[7:2]);
	endproperty
	property p_cc2;
		pe_ff == 8'h40 |=> third_port_pins_oe_n_o[1:0] == 2'h0
			&& third_port_pins_o[1:0] == {$past(capcomp2_output_a_i), $past(capcomp2_output_b_i)};
	endproperty
	property p_uart;
		pe_ff == 8'h10 |=> !third_port_pins_oe_n_o[6] && third_port_pins_o[6] == $past(uart_sync_clock_i);
	endproperty
	a_ack: assert property (p_ack) else $error("ack late or long");
	a_upper: assert property (p_upper) else $error("upper read bits set");
	a_rst: assert property (p_rst) else $error("pins not released in reset");
	a_dflt: assert property (p_dflt) else $error("pins not from latch");
	a_osc: assert property (p_osc) else $error("oscillator pins wrong");
	a_lcd: assert property (p_lcd) else $error("segment lines lost");
	a_cc2: assert property (p_cc2) else $error("capcomp2 pins wrong");
	a_uart: assert property (p_uart) else $error("uart clock pin wrong");
endmodule // bpo_port_chk
bind bpo_port bpo_port_chk u_chk (.*);

// *** sim/test_bidir_port_with_output_priority.sv ***
// self-checking bench for the bidirectional port
// assumes a classic wishbone master and the pin model outside
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module test_bidir_port_with_output_priority;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [7:0] adr_i, lcd_segment_line_i, pin_level_o, q, ext_en, ext_val;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic secondary_osc_output_i, ser_clk_i, ser_sck_i, ser_dat_i, ser_sdo_i;
	logic uart_sync_clock_i, uart_sync_data_i, uart_sync_mode_i, sel_28pin_i;
	logic capcomp1_output_a_i, capcomp2_output_a_i, capcomp2_output_b_i;
	logic capcomp3_output_a_i, capcomp3_output_b_i;
	logic [7:0] third_port_pins_i, third_port_pins_o, third_port_pins_oe_n_o;
	int miscompares, n_tests, cyc_cnt;
	bpo_port DUT (.*);
	bpo_pins_model u_pins (.clk_i(clk_i), .drv_i(third_port_pins_o),
		.oe_n_i(third_port_pins_oe_n_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.pins_o(third_port_pins_i));
	// 5 ns clock
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// hang guard, far above the run length
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 4000)
		begin
			miscompares++;
			final_report();
		end
	end
	// one classic cycle; held until ack is seen
	task automatic wb(input [7:0] a, input w, input [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		// no limit here; the hang guard ends a wait that never sees ack
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task t_reset();
		wb(8'h08, 1'b0, 8'h00);
		`CHK(q, 8'hFF)
		`CHK(third_port_pins_oe_n_o, 8'hFF)
		wb(8'h20, 1'b0, 8'h00); // unmapped place
		`CHK(q, 8'h00)
	endtask
	// low nibble driven, high nibble from outside
	task t_drive();
		wb(8'h08, 1'b1, 8'hF0);
		wb(8'h04, 1'b1, 8'hA5);
		`CHK(third_port_pins_oe_n_o, 8'hF0)
		`CHK(third_port_pins_o[3:0], 4'h5)
		wb(8'h00, 1'b0, 8'h00);
		`CHK(q, 8'h55)
		wb(8'h00, 1'b1, 8'h3C);
		wb(8'h04, 1'b0, 8'h00);
		`CHK(q, 8'h3C)
		`CHK(third_port_pins_o[3:0], 4'hC)
	endtask
	// analog low nibble reads zero, drivers still follow direction
	task t_analog();
		wb(8'h0C, 1'b1, 8'h0F);
		wb(8'h00, 1'b0, 8'h00);
		`CHK(q, 8'h50)
		`CHK(pin_level_o[3:0], 4'hC)
		`CHK(third_port_pins_oe_n_o, 8'hF0)
		wb(8'h08, 1'b1, 8'hFF);
	endtask
	// several enables at once; the higher one must win
	task t_prio();
		wb(8'h08, 1'b1, 8'h00); // latch drives every pin unless overridden
		wb(8'h10, 1'b1, 8'h03);
		`CHK(third_port_pins_o[0], secondary_osc_output_i)
		`CHK(third_port_pins_oe_n_o[1], 1'b1)
		`CHK(third_port_pins_o[7:2], lcd_segment_line_i[7:2])
		wb(8'h10, 1'b1, 8'h40);
		`CHK(third_port_pins_o[1:0], {capcomp2_output_a_i, capcomp2_output_b_i})
		wb(8'h10, 1'b1, 8'h0C);
		`CHK(third_port_pins_o[3], ser_clk_i)
		wb(8'h10, 1'b1, 8'h10);
		`CHK(third_port_pins_o[6], uart_sync_clock_i)
		// uart data idle outside sync mode: pin 7 falls to capcomp3
		sel_28pin_i <= 1'b1;
		uart_sync_mode_i <= 1'b0;
		capcomp3_output_b_i <= 1'b1;
		wb(8'h10, 1'b1, 8'hB0);
		`CHK(third_port_pins_o[2], capcomp1_output_a_i)
		`CHK(third_port_pins_o[7:6], {capcomp3_output_b_i, uart_sync_clock_i})
		wb(8'h10, 1'b1, 8'h00);
	endtask
	task final_report();
		$display("mismatches %0d of %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		sel_i = 4'hF;
		{ser_sck_i, ser_dat_i, ser_sdo_i, capcomp1_output_a_i, capcomp3_output_b_i} = '0;
		{secondary_osc_output_i, ser_clk_i, uart_sync_clock_i, capcomp2_output_a_i} = 4'hF;
		{capcomp2_output_b_i, uart_sync_data_i, uart_sync_mode_i, sel_28pin_i} = 4'h2;
		capcomp3_output_a_i = 1'b1;
		lcd_segment_line_i = 8'hA4;
		ext_en = 8'hFF;
		ext_val = 8'h5A;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_drive();
		t_analog();
		t_prio();
		final_report();
	end
endmodule // test_bidir_port_with_output_priority

// *** verilog/bpo_pin_mux.v ***
// per-pin output priority mux for the eight port pins
// assumes all peripheral inputs are on clk_i, combinational only
`include "bpo_port_map.vh"

module bpo_pin_mux
(
	// peripheral enables
	input  wire [7:0] pe_i,
	// port latch and direction
	input  wire [7:0] latch_i,
	input  wire [7:0] dir_i,
	// peripheral output values
	input  wire       osc_out_i,
	input  wire       osc_in_drv_i,
	input  wire [7:0] lcd_seg_i,
	input  wire       ser_clk_i,
	input  wire       ser_sck_i,
	input  wire       ser_dat_i,
	input  wire       ser_sdo_i,
	input  wire       uart_tx_i,
	input  wire       uart_dat_i,
	input  wire       cc1_a_i,
	input  wire       cc2_a_i,
	input  wire       cc2_b_i,
	input  wire       cc3_a_i,
	input  wire       cc3_b_i,
	input  wire       uart_sync_mode_i,
	input  wire       sel_28pin_i,
	// resolved pin value and driver enable
	output reg  [7:0] val_o,
	output reg  [7:0] drv_o
);

	// highest enabled function wins on each pin, port latch last
	always @*
	begin
		// port latch default: driver follows direction bit
		val_o = latch_i;
		drv_o = ~dir_i;
		// pins 0 and 1: oscillator, then capture/compare 2
		if (pe_i[`BPO_PE_OSC])
		begin
			val_o[`BPO_PIN0] = osc_out_i;
			drv_o[`BPO_PIN0] = `BPO_ONE;
			// oscillator input claims pin 1 and silences every other driver
			val_o[`BPO_PIN1] = osc_in_drv_i;
			drv_o[`BPO_PIN1] = `BPO_ZERO;
		end
		else if (pe_i[`BPO_PE_CC2])
		begin
			val_o[`BPO_PIN0] = cc2_b_i;
			drv_o[`BPO_PIN0] = `BPO_ONE;
			val_o[`BPO_PIN1] = cc2_a_i;
			drv_o[`BPO_PIN1] = `BPO_ONE;
		end
		// pin 2: lcd segment, then capture/compare 1
		if (pe_i[`BPO_PE_LCD])
		begin
			val_o[`BPO_PIN2] = lcd_seg_i[`BPO_PIN2];
			drv_o[`BPO_PIN2] = `BPO_ONE;
		end
		else if (pe_i[`BPO_PE_CC1])
		begin
			val_o[`BPO_PIN2] = cc1_a_i;
			drv_o[`BPO_PIN2] = `BPO_ONE;
		end
		// pin 3: lcd, serial clock (i2c), serial clock (spi)
		if (pe_i[`BPO_PE_LCD])
		begin
			val_o[`BPO_PIN3] = lcd_seg_i[`BPO_PIN3];
			drv_o[`BPO_PIN3] = `BPO_ONE;
		end
		else if (pe_i[`BPO_PE_SER_CLK])
		begin
			val_o[`BPO_PIN3] = ser_clk_i;
			drv_o[`BPO_PIN3] = `BPO_ONE;
		end
		else if (pe_i[`BPO_PE_SER_DAT])
		begin
			val_o[`BPO_PIN3] = ser_sck_i;
			drv_o[`BPO_PIN3] = `BPO_ONE;
		end
		// pin 4: lcd, i2c data; pin 5: lcd, spi data out
		if (pe_i[`BPO_PE_LCD])
		begin
			val_o[`BPO_PIN4] = lcd_seg_i[`BPO_PIN4];
			drv_o[`BPO_PIN4] = `BPO_ONE;
			val_o[`BPO_PIN5] = lcd_seg_i[`BPO_PIN5];
			drv_o[`BPO_PIN5] = `BPO_ONE;
		end
		else
		begin
			if (pe_i[`BPO_PE_SER_CLK])
			begin
				val_o[`BPO_PIN4] = ser_dat_i;
				drv_o[`BPO_PIN4] = `BPO_ONE;
			end
			if (pe_i[`BPO_PE_SER_DAT])
			begin
				val_o[`BPO_PIN5] = ser_sdo_i;
				drv_o[`BPO_PIN5] = `BPO_ONE;
			end
		end
		// pins 6 and 7: lcd, uart, capture/compare 3 (28-pin only)
		if (pe_i[`BPO_PE_LCD])
		begin
			val_o[`BPO_PIN6] = lcd_seg_i[`BPO_PIN6];
			drv_o[`BPO_PIN6] = `BPO_ONE;
			val_o[`BPO_PIN7] = lcd_seg_i[`BPO_PIN7];
			drv_o[`BPO_PIN7] = `BPO_ONE;
		end
		else
		begin
			// pin 6: uart clock wins over capture/compare 3
			if (pe_i[`BPO_PE_UART])
			begin
				val_o[`BPO_PIN6] = uart_tx_i;
				drv_o[`BPO_PIN6] = `BPO_ONE;
			end
			else if (pe_i[`BPO_PE_CC3] && sel_28pin_i)
			begin
				val_o[`BPO_PIN6] = cc3_a_i;
				drv_o[`BPO_PIN6] = `BPO_ONE;
			end
			// pin 7: uart data drives only in sync mode, else next in line
			if (pe_i[`BPO_PE_UART] && uart_sync_mode_i)
			begin
				val_o[`BPO_PIN7] = uart_dat_i;
				drv_o[`BPO_PIN7] = `BPO_ONE;
			end
			else if (pe_i[`BPO_PE_CC3] && sel_28pin_i)
			begin
				val_o[`BPO_PIN7] = cc3_b_i;
				drv_o[`BPO_PIN7] = `BPO_ONE;
			end
		end
	end

endmodule // bpo_pin_mux

// *** verilog/bpo_port.v ***
// eight-bit bidirectional port with wishbone registers and output priority
// assumes one clock clk_i, synchronous reset, pins from outside the clock domain
// limitation: a byte write replaces the whole latch, there is no per-bit mask
// limitation: the oscillator input pin is never driven from this block
//
// What this block does
// - eight pins, each individually input or output
// - direction one: pin input, driver off
// - direction zero: drive latch value onto pin
// - read returns pin levels; write updates latch
// - port writes replace the latch with the written byte
// - direction still controls drivers of analog pins
// - analog pins always read digital zero
// - highest priority enabled function drives pin
// - pins 0-2 priority: osc/lcd, capcomp, latch
// - pins 3-5 priority: lcd, serial, latch
// - pins 6-7 priority: lcd, uart, capcomp3, latch
// - inputs keep sampling while pin drives
// - oscillator input overrides port functions on pin
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`include "bpo_port_map.vh"

module bpo_port
(
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// peripheral outputs competing for the pins
	input  wire        secondary_osc_output_i,
	input  wire [7:0]  lcd_segment_line_i,
	input  wire        ser_clk_i,
	input  wire        ser_sck_i,
	input  wire        ser_dat_i,
	input  wire        ser_sdo_i,
	input  wire        uart_sync_clock_i,
	input  wire        uart_sync_data_i,
	input  wire        uart_sync_mode_i,
	input  wire        capcomp1_output_a_i,
	input  wire        capcomp2_output_a_i,
	input  wire        capcomp2_output_b_i,
	input  wire        capcomp3_output_a_i,
	input  wire        capcomp3_output_b_i,
	input  wire        sel_28pin_i,
	// synchronised pin levels for peripheral inputs
	output reg  [7:0]  pin_level_o,
	// pins: input, output, active-low output enable
	input  wire [7:0]  third_port_pins_i,
	output reg  [7:0]  third_port_pins_o,
	output reg  [7:0]  third_port_pins_oe_n_o
);

	// two-stage pin synchroniser
	reg  [7:0]  pin_meta_ff;           // first stage, read only by second
	reg  [7:0]  pin_sync_ff;           // second stage, safe to use
	// software registers
	reg  [7:0]  third_port_output_latch_ff;
	reg  [7:0]  third_port_direction_ff;
	reg  [7:0]  analog_sel_ff;         // one marks an analog input pin
	reg  [7:0]  periph_en_ff;          // peripheral output enables
	// bus handshake
	reg         ack_ff;
	reg  [31:0] rdat_ff;
	reg  [31:0] nxt_rdat;
	reg  [7:0]  nxt_latch;
	// mux results
	wire [7:0]  mux_val;
	wire [7:0]  mux_drv;
	// request qualification
	wire        req;
	wire        wr_lane0;
	// per-register write strobes
	wire        wr_pins;           // port data, read-modify-write path
	wire        wr_latch;          // output latch, direct
	wire        wr_dir;            // direction bits
	wire        wr_analog;         // analog select
	wire        wr_periph;         // peripheral enables

	// address match for a qualified write, shared by every register
	function bpo_wr_hit;
		input       wr;
		input [7:0] adr;
		input [7:0] target;
		begin
			// a write strobe on one register only
			bpo_wr_hit = wr & (adr == target);
		end
	endfunction

	// a fresh request only: the master still holds its request while the
	// internal ack and then ack_o stand, and neither cycle may retake it
	assign req      = cyc_i & stb_i & ~ack_ff & ~ack_o;
	// only byte lane 0 holds data, upper lanes read zero
	assign wr_lane0 = req & we_i & sel_i[0];
	// one write strobe per register, decoded once
	assign wr_pins   = bpo_wr_hit(wr_lane0, adr_i, `BPO_ADDR_PINS);
	assign wr_latch  = bpo_wr_hit(wr_lane0, adr_i, `BPO_ADDR_LATCH);
	assign wr_dir    = bpo_wr_hit(wr_lane0, adr_i, `BPO_ADDR_DIR);
	assign wr_analog = bpo_wr_hit(wr_lane0, adr_i, `BPO_ADDR_ANALOG);
	assign wr_periph = bpo_wr_hit(wr_lane0, adr_i, `BPO_ADDR_PERIPH);

	// digital view of a pin: analog pins read zero
	function [7:0] bpo_digital;
		input [7:0] lvl;
		input [7:0] ana;
		begin
			// an analog pin has no digital meaning
			bpo_digital = lvl & ~ana;
		end
	endfunction

	// merge written byte into sampled pin levels
	function [7:0] bpo_rmw;
		input [7:0] pins;
		input [7:0] wdat;
		input       lane;
		begin
			// a full-lane write replaces every bit; no lane keeps pins
			bpo_rmw = lane ? wdat : pins;
		end
	endfunction

	// pin synchroniser, keeps sampling even while driving
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// clear both stages so no stale level leaks out of reset
			pin_meta_ff <= 8'h00;
			pin_sync_ff <= 8'h00;
		end
		else
		begin
			// first stage may go metastable, nothing else reads it
			pin_meta_ff <= third_port_pins_i;
			// second stage feeds the read path and the peripherals
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// next latch value for a data register write
	always @*
	begin
		// no write: the latch holds its value
		nxt_latch = third_port_output_latch_ff;
		if (wr_pins)
		begin
			// the port path reads the pins first, then stores the merge
			nxt_latch = bpo_rmw(bpo_digital(pin_sync_ff, analog_sel_ff),
				dat_i[7:0], sel_i[0]);
		end
		else if (wr_latch)
		begin
			// direct latch access skips the pin read
			nxt_latch = dat_i[7:0];
		end
	end

	// output latch; only the two data paths above change its next value
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			third_port_output_latch_ff <= `BPO_RST_LATCH;
		end
		else
		begin
			third_port_output_latch_ff <= nxt_latch;
		end
	end

	// direction bits
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// all inputs out of reset, so no pin drives before software
			third_port_direction_ff <= `BPO_RST_DIR;
		end
		else if (wr_dir)
		begin
			// a one bit turns its pin into an input
			third_port_direction_ff <= dat_i[7:0];
		end
	end

	// analog select
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// every pin digital out of reset
			analog_sel_ff <= `BPO_RST_ANALOG;
		end
		else if (wr_analog)
		begin
			// analog select never touches drivers; software keeps dir set
			analog_sel_ff <= dat_i[7:0];
		end
	end

	// peripheral enables, one bit per competing function
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// the port latch owns every pin out of reset
			periph_en_ff <= `BPO_RST_PERIPH;
		end
		else if (wr_periph)
		begin
			periph_en_ff <= dat_i[7:0];
		end
	end

	// one byte register widened to the bus word, upper lanes zero
	function [31:0] bpo_word;
		input [7:0] val;
		begin
			bpo_word = {`BPO_ZERO24, val};
		end
	endfunction

	// read data decode, unmapped addresses read zero
	always @*
	begin
		nxt_rdat = 32'h00000000;
		case (adr_i)
			// port data: pin levels, analog pins masked to zero
			`BPO_ADDR_PINS:
				nxt_rdat = bpo_word(bpo_digital(pin_sync_ff,
					analog_sel_ff));
			// the other registers read back as written
			`BPO_ADDR_LATCH:
				nxt_rdat = bpo_word(third_port_output_latch_ff);
			`BPO_ADDR_DIR:
				nxt_rdat = bpo_word(third_port_direction_ff);
			`BPO_ADDR_ANALOG:
				nxt_rdat = bpo_word(analog_sel_ff);
			`BPO_ADDR_PERIPH:
				nxt_rdat = bpo_word(periph_en_ff);
			// holes in the map answer with zero
			default:
				nxt_rdat = 32'h00000000;
		endcase
	end

	// one-cycle ack for every request, mapped or not
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// no answer pending out of reset
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h00000000;
		end
		else
		begin
			// first stage of the ack, set only by a fresh request
			ack_ff  <= req;
			// data is captured with the request; idle cycles keep it zero
			rdat_ff <= req ? nxt_rdat : 32'h00000000;
		end
	end

	// priority mux between peripherals and the port latch
	bpo_pin_mux u_mux
	(
		// enables and port registers
		.pe_i             (periph_en_ff),
		.latch_i          (third_port_output_latch_ff),
		.dir_i            (third_port_direction_ff),
		// peripheral values; the oscillator input pin is never driven
		.osc_out_i        (secondary_osc_output_i),
		.osc_in_drv_i     (1'b0),
		.lcd_seg_i        (lcd_segment_line_i),
		.ser_clk_i        (ser_clk_i),
		.ser_sck_i        (ser_sck_i),
		.ser_dat_i        (ser_dat_i),
		.ser_sdo_i        (ser_sdo_i),
		.uart_tx_i        (uart_sync_clock_i),
		.uart_dat_i       (uart_sync_data_i),
		.cc1_a_i          (capcomp1_output_a_i),
		.cc2_a_i          (capcomp2_output_a_i),
		.cc2_b_i          (capcomp2_output_b_i),
		.cc3_a_i          (capcomp3_output_a_i),
		.cc3_b_i          (capcomp3_output_b_i),
		// mode and package straps
		.uart_sync_mode_i (uart_sync_mode_i),
		.sel_28pin_i      (sel_28pin_i),
		// resolved drive, registered below
		.val_o            (mux_val),
		.drv_o            (mux_drv)
	);

	// registered pin drive; a write shows on the pins one edge later
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// out of reset every driver is off
			third_port_pins_o      <= 8'h00;
			third_port_pins_oe_n_o <= 8'hFF;
		end
		else
		begin
			third_port_pins_o      <= mux_val;
			third_port_pins_oe_n_o <= ~mux_drv;
		end
	end

	// registered bus answer and pin levels for the peripherals
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_level_o <= 8'h00;
			dat_o       <= 32'h00000000;
			ack_o       <= 1'b0;
		end
		else
		begin
			// peripherals see raw synced levels, analog or not
			pin_level_o <= pin_sync_ff;
			// read data stands with ack for one cycle
			dat_o       <= rdat_ff;
			// second stage of the ack; it also blocks a retake
			ack_o       <= ack_ff;
		end
	end

endmodule // bpo_port
